// ===== inc/sft_pkg.sv
// constants, modes and carrier types of the supply and thermal fault status bank
package sft_pkg;

    // register addresses carried in the 7-bit address field
    localparam logic [6:0] SFT_ADDR_SUP_HIGH  = 7'h40;
    localparam logic [6:0] SFT_ADDR_SUP_LOW   = 7'h41;
    localparam logic [6:0] SFT_ADDR_THERM     = 7'h42;

    // reset and restart values
    localparam logic [7:0] SFT_SUP_HIGH_RST   = 8'h00;
    localparam logic [7:0] SFT_SUP_LOW_POR    = 8'h80;
    localparam logic [7:0] SFT_SUP_LOW_SOFT   = 8'h00;
    localparam logic [7:0] SFT_THERM_RST      = 8'h00;
    localparam logic [7:0] SFT_THERM_RESTART  = 8'h0F;
    localparam logic [7:0] SFT_READ_UNMAPPED  = 8'h00;

    // implemented bits of each register, everything else reads zero
    localparam logic [7:0] SFT_SUP_HIGH_USED  = 8'h63;
    localparam logic [7:0] SFT_SUP_LOW_USED   = 8'h9D;
    localparam logic [7:0] SFT_THERM_USED     = 8'h0F;

    // field positions, first supply register
    localparam int unsigned SFT_B_BATT_LOW    = 6;
    localparam int unsigned SFT_B_BATT_HIGH   = 5;
    localparam int unsigned SFT_B_MAIN_OVER   = 1;
    localparam int unsigned SFT_B_MAIN_PREW   = 0;
    // field positions, second supply register
    localparam int unsigned SFT_B_POR         = 7;
    localparam int unsigned SFT_B_AUX_HOT     = 4;
    localparam int unsigned SFT_B_AUX_LOW     = 3;
    localparam int unsigned SFT_B_MAIN_SHORT  = 2;
    localparam int unsigned SFT_B_MAIN_LOW    = 0;
    // field positions, thermal register
    localparam int unsigned SFT_B_SAFE        = 3;
    localparam int unsigned SFT_B_SEVERE      = 2;
    localparam int unsigned SFT_B_MODULE      = 1;
    localparam int unsigned SFT_B_TPREW       = 0;

    // serial frame layout, bit 0 first
    localparam int unsigned SFT_B_ACCESS      = 7;
    localparam logic [4:0]  SFT_LAST_ADDR_BIT = 5'h07;
    localparam logic [4:0]  SFT_FIRST_DATA    = 5'h08;
    localparam logic [4:0]  SFT_LAST_BIT      = 5'h0F;

    // timing
    localparam int unsigned SFT_CLK_MHZ       = 100;
    localparam int unsigned SFT_SHORT_TIME_US = 2000;
    localparam int unsigned SFT_SHORT_CYCLES  = SFT_SHORT_TIME_US * SFT_CLK_MHZ;
    localparam logic [4:0]  SFT_SAFE_EVENTS   = 5'h10;
    localparam logic [4:0]  SFT_EVENT_MAX     = 5'h1F;

    // operating modes of the device
    typedef enum logic [2:0] {
        SFT_MODE_INIT,
        SFT_MODE_NORMAL,
        SFT_MODE_STOP,
        SFT_MODE_SLEEP,
        SFT_MODE_RESTART,
        SFT_MODE_FAIL_SAFE
    } sft_mode_t;

    // serial frame receiver states
    typedef enum logic [2:0] {
        SFT_SPI_IDLE,
        SFT_SPI_ADDR,
        SFT_SPI_DATA,
        SFT_SPI_FULL,
        SFT_SPI_BAD
    } sft_spi_t;

    // comparator levels from the analog side, asynchronous
    typedef struct packed {
        logic battery_low;
        logic battery_high;
        logic main_reg_over;
        logic main_reg_prewarn;
        logic aux_reg_hot;
        logic aux_reg_low;
        logic main_reg_below_reset;
        logic load_peak_threshold;
        logic thermal_prewarn;
        logic module_shutdown;
        logic severe_shutdown;
    } sft_det_t;

    // control from the mode logic, same clock
    typedef struct packed {
        sft_mode_t mode;
        logic      main_reg_enabled;
        logic      charge_pump_on;
        logic      reset_out_n;
        logic      soft_reset;
        logic      restart_entry;
    } sft_ctrl_t;

endpackage : sft_pkg

// ===== rtl/sft_hold_timer.sv
// timer that flags a level held for more than a given number of cycles
`timescale 1ns/100ps
module sft_hold_timer
    import sft_pkg::*;
#(
    parameter int unsigned LIMIT = SFT_SHORT_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      expired
);
    localparam int unsigned CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          expired;
    } sft_tmr_t;

    sft_tmr_t s_reg;
    sft_tmr_t s_next;

    // count while held, expire one cycle past the limit, restart on drop
    always_comb begin
        s_next = s_reg;
        if (!run) begin
            s_next.count   = '0;
            s_next.expired = 1'b0;
        end else begin
            if (s_reg.count < LIM) begin
                s_next.count = s_reg.count + CW'(1);
            end
            s_next.expired = (s_reg.count >= LIM);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign expired = s_reg.expired;

endmodule : sft_hold_timer

// ===== rtl/sft_status_bank.sv
// supply and thermal fault status bank with its serial register port
`timescale 1ns/100ps

// Notes on behaviour
// R1: reserved bits of all three status registers always read zero
// R2: battery low flag latches only while the main regulator is enabled
// R3: battery high flag latches only while the main regulator is enabled
// R4: main regulator overvoltage latches its flag
// R5: main regulator prewarning latches its flag, own fixed threshold
// R6: stop mode blocks battery low unless high load or prewarning flag set
// R7: battery high always active with charge pump, in stop only on load or prewarn
// R8: power-on leaves second supply register at 0x80, soft reset leaves zero
// R9: aux regulator overtemperature latches its flag
// R10: aux regulator undervoltage latches its flag
// R11: main regulator short flag after below reset level over 2 ms
// R12: main regulator reset threshold crossing latches undervoltage flag
// R13: sleep with main regulator off sets no short, over or low flags
// R14: main low never in restart, init after reset release, always on short
// R15: thermal register zero on reset, restart keeps only low nibble
// R16: safe state flag after more than 16 consecutive severe shutdowns
// R17: severe shutdown latches flag and requests fail-safe mode
// R18: module shutdown latches flag and disables the affected module
// R19: thermal prewarning latches its flag
// R20: thermal flags stay set after cause goes, cleared only by host
// R21: host frame access bit 7 one clears the byte, zero only reads
// R22: status flags never clear or change on their own
// R23: a set in the same cycle as a host clear wins
module sft_status_bank
    import sft_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = SFT_SHORT_CYCLES
) (
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire logic      spi_sclk,
    input  wire logic      spi_cs_n,
    input  wire logic      spi_mosi,
    output logic           spi_miso,
    output logic           spi_miso_oe,
    input  wire sft_det_t  det,
    input  wire sft_ctrl_t ctrl,
    output logic           fail_safe_req,
    output logic           module_disable,
    output logic           safe_wait_long
);

    typedef struct packed {
        logic [1:0] sclk_sy;
        logic [1:0] cs_n_sy;
        logic [1:0] mosi_sy;
        logic       sclk_last;
        logic       cs_last;
        sft_det_t   det_s1;
        sft_det_t   det_s2;
        sft_spi_t   spi_st;
        logic [4:0] bit_cnt;
        logic [7:0] rx_addr;
        logic [7:0] tx_shift;
        logic       miso;
        logic       miso_oe;
        logic [7:0] sup_high;
        logic [7:0] sup_low;
        logic [7:0] therm;
        logic [4:0] severe_cnt;
        logic       severe_last;
        logic       fail_safe;
    } sft_state_t;

    sft_state_t s_reg;
    sft_state_t s_next;

    logic       short_run;
    logic       short_hit;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_act;
    logic       allow_main;
    logic       low_ok;
    logic       high_ok;
    logic       main_low_upd;
    logic       severe_rise;
    logic       safe_hit;
    logic [7:0] rd_val;
    logic [7:0] set_high;
    logic [7:0] set_low;
    logic [7:0] set_therm;
    logic [2:0] clr_sel;
    sft_det_t   d;

    assign d = s_reg.det_s2;

    // short to ground: below reset level held while the regulator is on
    assign short_run = ctrl.main_reg_enabled & d.main_reg_below_reset; // R11

    sft_hold_timer #(
        .LIMIT (SHORT_CYCLES)
    ) u_short_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (short_run),
        .expired (short_hit)
    );

    // edges seen on the second synchroniser stage only
    assign sclk_rise = s_reg.sclk_sy[1] & ~s_reg.sclk_last;
    assign sclk_fall = ~s_reg.sclk_sy[1] & s_reg.sclk_last;
    assign cs_act    = ~s_reg.cs_n_sy[1];

    // qualification of the battery, main overvoltage, short and main low flags by operating mode
    always_comb begin
        allow_main = !((ctrl.mode == SFT_MODE_SLEEP) && !ctrl.main_reg_enabled); // R13
        low_ok     = ctrl.main_reg_enabled &&
                     ((ctrl.mode != SFT_MODE_STOP) || d.load_peak_threshold ||
                      s_reg.sup_high[SFT_B_MAIN_PREW]); // R2 R6
        high_ok    = ctrl.main_reg_enabled &&
                     (ctrl.charge_pump_on || (ctrl.mode != SFT_MODE_STOP) ||
                      d.load_peak_threshold || s_reg.sup_high[SFT_B_MAIN_PREW]); // R3 R7
        main_low_upd = allow_main &&
                       (short_hit || (ctrl.mode == SFT_MODE_NORMAL) ||
                        (ctrl.mode == SFT_MODE_STOP) ||
                        ((ctrl.mode == SFT_MODE_INIT) && ctrl.reset_out_n)); // R14
    end

    // severe shutdown events counted until normal operation resumes
    assign severe_rise = d.severe_shutdown & ~s_reg.severe_last;
    assign safe_hit    = severe_rise && (s_reg.severe_cnt >= SFT_SAFE_EVENTS); // R16

    // set terms, reserved positions never set
    always_comb begin
        set_high = '0;
        set_low  = '0;
        set_therm = '0;
        set_high[SFT_B_BATT_LOW]   = low_ok & d.battery_low; // R2
        set_high[SFT_B_BATT_HIGH]  = high_ok & d.battery_high; // R3
        set_high[SFT_B_MAIN_OVER]  = allow_main & d.main_reg_over; // R4
        set_high[SFT_B_MAIN_PREW]  = d.main_reg_prewarn; // R5
        set_low[SFT_B_AUX_HOT]     = d.aux_reg_hot; // R9
        set_low[SFT_B_AUX_LOW]     = d.aux_reg_low; // R10
        set_low[SFT_B_MAIN_SHORT]  = allow_main & short_hit; // R11
        set_low[SFT_B_MAIN_LOW]    = main_low_upd & d.main_reg_below_reset; // R12
        set_therm[SFT_B_SAFE]      = safe_hit; // R16
        set_therm[SFT_B_SEVERE]    = d.severe_shutdown; // R17
        set_therm[SFT_B_MODULE]    = d.module_shutdown; // R18
        set_therm[SFT_B_TPREW]     = d.thermal_prewarn; // R19
    end

    // read data, unmapped addresses answer zero
    always_comb begin
        unique case (s_reg.rx_addr[6:0])
            SFT_ADDR_SUP_HIGH: rd_val = s_reg.sup_high & SFT_SUP_HIGH_USED; // R1
            SFT_ADDR_SUP_LOW:  rd_val = s_reg.sup_low & SFT_SUP_LOW_USED; // R1
            SFT_ADDR_THERM:    rd_val = s_reg.therm & SFT_THERM_USED; // R1
            default:           rd_val = SFT_READ_UNMAPPED;
        endcase
    end

    // frame receiver, status update and event counting
    always_comb begin
        s_next  = s_reg;
        clr_sel = 3'b000;

        // two-stage synchronisers, first stage feeds the second only
        s_next.sclk_sy   = {s_reg.sclk_sy[0], spi_sclk};
        s_next.cs_n_sy   = {s_reg.cs_n_sy[0], spi_cs_n};
        s_next.mosi_sy   = {s_reg.mosi_sy[0], spi_mosi};
        s_next.det_s1    = det;
        s_next.det_s2    = s_reg.det_s1;
        s_next.sclk_last = s_reg.sclk_sy[1];
        s_next.cs_last   = s_reg.cs_n_sy[1];

        unique case (s_reg.spi_st)
            SFT_SPI_IDLE: begin
                s_next.miso    = 1'b0;
                s_next.miso_oe = 1'b0;
                if (cs_act) begin
                    s_next.spi_st  = SFT_SPI_ADDR;
                    s_next.bit_cnt = '0;
                    s_next.miso_oe = 1'b1;
                end
            end
            SFT_SPI_ADDR: begin
                if (!cs_act) begin
                    s_next.spi_st = SFT_SPI_IDLE;
                end else if (sclk_rise) begin
                    s_next.rx_addr[s_reg.bit_cnt[2:0]] = s_reg.mosi_sy[1];
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.bit_cnt == SFT_LAST_ADDR_BIT) begin
                        s_next.spi_st = SFT_SPI_DATA;
                    end
                end
            end
            SFT_SPI_DATA: begin
                // short frames are dropped without any clear
                if (!cs_act) begin
                    s_next.spi_st = SFT_SPI_IDLE;
                end else if (sclk_rise) begin
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.bit_cnt == SFT_LAST_BIT) begin
                        s_next.spi_st = SFT_SPI_FULL;
                    end
                end else if (sclk_fall) begin
                    if (s_reg.bit_cnt == SFT_FIRST_DATA) begin
                        s_next.tx_shift = rd_val;
                        s_next.miso     = rd_val[0];
                    end else begin
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
                        s_next.miso     = s_reg.tx_shift[1];
                    end
                end
            end
            SFT_SPI_FULL: begin
                if (!cs_act) begin
                    // clear only on a whole frame with the access bit set
                    if (s_reg.rx_addr[SFT_B_ACCESS]) begin // R21
                        clr_sel[0] = (s_reg.rx_addr[6:0] == SFT_ADDR_SUP_HIGH);
                        clr_sel[1] = (s_reg.rx_addr[6:0] == SFT_ADDR_SUP_LOW);
                        clr_sel[2] = (s_reg.rx_addr[6:0] == SFT_ADDR_THERM);
                    end
                    s_next.spi_st = SFT_SPI_IDLE;
                end else if (sclk_rise) begin
                    s_next.spi_st = SFT_SPI_BAD;
                end
            end
            SFT_SPI_BAD: begin
                if (!cs_act) begin
                    s_next.spi_st = SFT_SPI_IDLE;
                end
            end
            default: begin
                s_next.spi_st = SFT_SPI_IDLE;
            end
        endcase

        // sticky flags: clear first, then the set wins over it
        s_next.sup_high = ((clr_sel[0] ? 8'h00 : s_reg.sup_high) | set_high)
                          & SFT_SUP_HIGH_USED; // R22 R23 R1
        s_next.sup_low  = ((clr_sel[1] ? 8'h00 : s_reg.sup_low) | set_low)
                          & SFT_SUP_LOW_USED; // R22 R23 R1
        s_next.therm    = ((clr_sel[2] ? 8'h00 : s_reg.therm) | set_therm)
                          & SFT_THERM_USED; // R20 R23 R1

        // consecutive severe events, run resets once normal mode is back
        s_next.severe_last = d.severe_shutdown;
        s_next.fail_safe   = severe_rise; // R17
        if (severe_rise) begin
            if (s_reg.severe_cnt != SFT_EVENT_MAX) begin
                s_next.severe_cnt = s_reg.severe_cnt + 5'h01;
            end
        end else if (ctrl.mode == SFT_MODE_NORMAL) begin
            s_next.severe_cnt = '0;
        end

        // restart keeps the thermal low nibble only
        if (ctrl.restart_entry) begin
            s_next.therm = s_next.therm & SFT_THERM_RESTART; // R15
        end

        // soft reset takes every register to its soft value
        if (ctrl.soft_reset) begin
            s_next.sup_high   = SFT_SUP_HIGH_RST;
            s_next.sup_low    = SFT_SUP_LOW_SOFT; // R8
            s_next.therm      = SFT_THERM_RST; // R15
            s_next.severe_cnt = '0;
        end
    end

    // power-on reset marks the power-on bit, chip select idles high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg          <= '0;
            s_reg.cs_n_sy  <= 2'b11;
            s_reg.cs_last  <= 1'b1;
            s_reg.sup_high <= SFT_SUP_HIGH_RST;
            s_reg.sup_low  <= SFT_SUP_LOW_POR; // R8
            s_reg.therm    <= SFT_THERM_RST; // R15
        end else begin
            s_reg <= s_next;
        end
    end

    assign spi_miso       = s_reg.miso;
    assign spi_miso_oe    = s_reg.miso_oe;
    assign fail_safe_req  = s_reg.fail_safe;
    assign module_disable = s_reg.therm[SFT_B_MODULE]; // R18
    assign safe_wait_long = s_reg.therm[SFT_B_SAFE]; // R16

    // helper: cycles the short condition has been held
    logic [31:0] run_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= '0;
        end else if (!short_run) begin
            run_cnt <= '0;
        end else if (run_cnt != 32'hFFFF_FFFF) begin
            run_cnt <= run_cnt + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence sev_event_s;
        severe_rise;
    endsequence

    sequence fail_req_s;
        fail_safe_req ##1 !fail_safe_req;
    endsequence

    reserved_bits_zero_a: assert property ( // R1
        ((s_reg.sup_high & ~SFT_SUP_HIGH_USED) == 8'h00) &&
        ((s_reg.sup_low & ~SFT_SUP_LOW_USED) == 8'h00) &&
        ((s_reg.therm & ~SFT_THERM_USED) == 8'h00))
        else $error("reserved status bit set");

    batt_low_set_a: assert property ( // R2
        (low_ok && d.battery_low && !ctrl.soft_reset) |=> s_reg.sup_high[SFT_B_BATT_LOW])
        else $error("battery low flag not latched");

    batt_low_stop_a: assert property ( // R6
        $rose(s_reg.sup_high[SFT_B_BATT_LOW]) |-> $past(low_ok))
        else $error("battery low flag set while blocked");

    batt_high_pump_a: assert property ( // R7
        (ctrl.charge_pump_on && ctrl.main_reg_enabled && d.battery_high &&
         !ctrl.soft_reset) |=> s_reg.sup_high[SFT_B_BATT_HIGH])
        else $error("battery high missed with charge pump on");

    soft_reset_zero_a: assert property ( // R8
        ctrl.soft_reset |=> (s_reg.sup_low == SFT_SUP_LOW_SOFT) &&
                            (s_reg.therm == SFT_THERM_RST))
        else $error("soft reset value wrong");

    short_delay_a: assert property ( // R11
        $rose(s_reg.sup_low[SFT_B_MAIN_SHORT]) |-> $past(run_cnt, 2) >= SHORT_CYCLES)
        else $error("short flag set too early");

    sleep_block_a: assert property ( // R13
        ((ctrl.mode == SFT_MODE_SLEEP) && !ctrl.main_reg_enabled &&
         !s_reg.sup_low[SFT_B_MAIN_SHORT]) |=> !s_reg.sup_low[SFT_B_MAIN_SHORT])
        else $error("short flag set in sleep with regulator off");

    restart_hold_a: assert property ( // R14
        ((ctrl.mode == SFT_MODE_RESTART) && !short_hit &&
         !s_reg.sup_low[SFT_B_MAIN_LOW]) |=> !s_reg.sup_low[SFT_B_MAIN_LOW])
        else $error("main low flag updated in restart");

    safe_count_a: assert property ( // R16
        $rose(s_reg.therm[SFT_B_SAFE]) |-> $past(s_reg.severe_cnt) >= SFT_SAFE_EVENTS)
        else $error("safe state flag before enough events");

    fail_safe_pulse_a: assert property ( // R17
        sev_event_s |=> fail_req_s)
        else $error("fail-safe request not pulsed");

    thermal_sticky_a: assert property ( // R20
        (s_reg.therm[SFT_B_SEVERE] && !clr_sel[2] && !ctrl.soft_reset)
        |=> s_reg.therm[SFT_B_SEVERE])
        else $error("severe flag dropped on its own");

    set_over_clear_a: assert property ( // R23
        (clr_sel[2] && d.thermal_prewarn && !ctrl.soft_reset)
        |=> s_reg.therm[SFT_B_TPREW])
        else $error("clear beat a simultaneous set");

endmodule : sft_status_bank

// ===== verif/sft_host_model.sv
// host-side serial master model for the status bank
`timescale 1ns/100ps
module sft_host_model
    import sft_pkg::*;
(
    input  wire logic sys_clk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe
);
    localparam int HALF = 6; // margin over the 4-cycle minimum half period

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // one 16-bit frame, bit 0 first; data byte sampled on each rise
    task automatic xfer(input logic [6:0] a, input logic acc, output logic [7:0] rdata);
        logic [7:0] word;
        word = {acc, a};
        rdata = 8'h00;
        @(posedge sys_clk);
        spi_cs_n <= 1'b0;
        spi_mosi <= word[0];
        for (int i = 0; i < 16; i++) begin
            repeat (HALF) @(posedge sys_clk);
            spi_sclk <= 1'b1;
            if (i >= 8) rdata[i-8] = spi_miso;
            repeat (HALF) @(posedge sys_clk);
            spi_sclk <= 1'b0;
            // data byte in is ignored; keep the line moving so nothing relies on it
            spi_mosi <= (i < 7) ? word[i+1] : ~spi_mosi;
        end
        repeat (HALF) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask : xfer
endmodule : sft_host_model

// ===== verif/sft_status_bank_test.sv
// self-checking bench for the supply and thermal fault status bank
`timescale 1ns/100ps
module sft_status_bank_test;
    import sft_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic       fail_safe_req, module_disable, safe_wait_long;
    sft_det_t   det;
    sft_ctrl_t  ctrl;
    logic [7:0] rd_val;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         pulses = 0;
    int         oe_cycles = 0;

    // short timer cut down so the run stays brief
    sft_status_bank #(.SHORT_CYCLES(20)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .det(det), .ctrl(ctrl), .fail_safe_req(fail_safe_req),
        .module_disable(module_disable), .safe_wait_long(safe_wait_long)
    );
    sft_host_model u_host (
        .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
    );

    always #5 sys_clk = ~sys_clk;
    // one request per severe event expected
    always @(posedge sys_clk) if (fail_safe_req === 1'b1) pulses++;
    // cycles in which the bank claims the data line
    always @(posedge sys_clk) if (spi_miso_oe === 1'b1) oe_cycles++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        u_host.xfer(a, 1'b0, rd_val);
        chk(rd_val, exp);
    endtask : rd
    task automatic clr_all;
        u_host.xfer(SFT_ADDR_SUP_HIGH, 1'b1, rd_val);
        u_host.xfer(SFT_ADDR_SUP_LOW, 1'b1, rd_val);
        u_host.xfer(SFT_ADDR_THERM, 1'b1, rd_val);
    endtask : clr_all
    // bits: batt_low batt_high over prew aux_hot aux_low below load tprew module severe
    task automatic hit(input sft_det_t d, input int n);
        @(posedge sys_clk);
        det <= d;
        repeat (n) @(posedge sys_clk);
        det <= '0;
        repeat (4) @(posedge sys_clk);
    endtask : hit
    task automatic md(input sft_mode_t m, input logic en, input logic cp, input logic rn);
        @(posedge sys_clk);
        ctrl <= '{m, en, cp, rn, 1'b0, 1'b0};
    endtask : md
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    // hang guard, well above the expected eight thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        det = '0;
        ctrl = '{SFT_MODE_NORMAL, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(SFT_ADDR_SUP_HIGH, 8'h00);
        rd(SFT_ADDR_SUP_LOW, 8'h80);
        rd(SFT_ADDR_THERM, 8'h00);
        rd(7'h43, 8'h00);
        chk(spi_miso_oe, 1'b0);
        chk(oe_cycles != 0, 1'b1);
        $display("reset values done");
        // every comparator except load peak at once, below-reset long enough for the short flag
        hit(11'h7F7, 40);
        rd(SFT_ADDR_SUP_HIGH, 8'h63);
        rd(SFT_ADDR_SUP_HIGH, 8'h63);
        rd(SFT_ADDR_SUP_LOW, 8'h9D);
        rd(SFT_ADDR_THERM, 8'h07);
        chk(module_disable, 1'b1);
        chk(pulses, 1);
        clr_all();
        rd(SFT_ADDR_SUP_HIGH, 8'h00);
        rd(SFT_ADDR_SUP_LOW, 8'h00);
        rd(SFT_ADDR_THERM, 8'h00);
        chk(module_disable, 1'b0);
        // prewarning held across a clear frame, the set must survive it
        @(posedge sys_clk);
        det <= 11'h004;
        u_host.xfer(SFT_ADDR_THERM, 1'b1, rd_val);
        rd(SFT_ADDR_THERM, 8'h01);
        det <= '0;
        u_host.xfer(SFT_ADDR_THERM, 1'b1, rd_val);
        rd(SFT_ADDR_THERM, 8'h00);
        $display("latch and clear done");
        md(SFT_MODE_STOP, 1'b1, 1'b0, 1'b1);
        hit(11'h600, 10);
        rd(SFT_ADDR_SUP_HIGH, 8'h00);
        md(SFT_MODE_STOP, 1'b1, 1'b1, 1'b1);
        hit(11'h600, 10);
        rd(SFT_ADDR_SUP_HIGH, 8'h20);
        hit(11'h608, 10);
        rd(SFT_ADDR_SUP_HIGH, 8'h60);
        clr_all();
        $display("stop mode done");
        md(SFT_MODE_SLEEP, 1'b0, 1'b0, 1'b1);
        hit(11'h710, 40);
        rd(SFT_ADDR_SUP_HIGH, 8'h00);
        rd(SFT_ADDR_SUP_LOW, 8'h00);
        md(SFT_MODE_RESTART, 1'b1, 1'b0, 1'b1);
        hit(11'h010, 10);
        rd(SFT_ADDR_SUP_LOW, 8'h00);
        md(SFT_MODE_INIT, 1'b1, 1'b0, 1'b0);
        hit(11'h010, 10);
        rd(SFT_ADDR_SUP_LOW, 8'h00);
        md(SFT_MODE_INIT, 1'b1, 1'b0, 1'b1);
        hit(11'h010, 10);
        rd(SFT_ADDR_SUP_LOW, 8'h01);
        clr_all();
        $display("mode gating done");
        // sixteen severe events must not yet reach the safe state
        md(SFT_MODE_FAIL_SAFE, 1'b1, 1'b0, 1'b1);
        repeat (16) hit(11'h001, 3);
        chk(safe_wait_long, 1'b0);
        hit(11'h001, 3);
        chk(safe_wait_long, 1'b1);
        chk(pulses, 18);
        rd(SFT_ADDR_THERM, 8'h0C);
        $display("thermal safe state done");
        hit(11'h040, 5);
        @(posedge sys_clk);
        ctrl.restart_entry <= 1'b1;
        @(posedge sys_clk);
        ctrl.restart_entry <= 1'b0;
        rd(SFT_ADDR_THERM, 8'h0C);
        @(posedge sys_clk);
        ctrl.soft_reset <= 1'b1;
        @(posedge sys_clk);
        ctrl.soft_reset <= 1'b0;
        rd(SFT_ADDR_SUP_LOW, 8'h00);
        rd(SFT_ADDR_THERM, 8'h00);
        chk(safe_wait_long, 1'b0);
        $display("restart and soft reset done");
        summarize();
    end
endmodule : sft_status_bank_test
